// file: msq_pkg.sv
// Shared types and constants of the motion state table sequencer
`default_nettype none
package msq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Table geometry
  localparam int unsigned STATES    = 64;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned AXES      = 4;
  localparam int unsigned AXIS_W    = 2;
  localparam int unsigned POS_W     = 32;
  localparam int unsigned LIM_W     = 16;
  localparam int unsigned CUR_W     = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [POS_W-1:0] TARGET_RST = 32'h0000_0000;
  localparam logic [LIM_W-1:0] LIMIT_RST  = 16'h0000;
  localparam logic [CUR_W-1:0] CUR_RST    = 16'h0000;
  localparam logic             INPOS_RST  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Entry operations
  typedef enum logic [2:0] {
    OP_NOP     = 3'h0,
    OP_ABS_POS = 3'h1,
    OP_REL_POS = 3'h2,
    OP_ABS_CUR = 3'h3,
    OP_REL_CUR = 3'h4
  } msq_op_type;

  // One stored command for one actuator
  typedef struct packed {
    msq_op_type        op;
    logic [POS_W-1:0]  value;
    logic [LIM_W-1:0]  speed;
    logic [LIM_W-1:0]  accel;
  } msq_entry_type;

  // Command handed to one actuator's trajectory stage
  typedef struct packed {
    logic [POS_W-1:0]  target;
    logic [LIM_W-1:0]  speed;
    logic [LIM_W-1:0]  accel;
    logic [CUR_W-1:0]  current;
  } msq_axis_type;

endpackage : msq_pkg

`default_nettype wire

// file: msq_sequencer.sv
// Table-driven motion state sequencer for four actuators
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Table stores up to 64 selectable states
// - Each state holds one command per actuator
// - No-op leaves actuator; running move completes
// - Absolute move targets position from zero, limited
// - Absolute move arrival raises target-reached
// - Relative move adds to current target
// - Relative move limited; arrival raises target-reached
// - Absolute current only on solenoid outputs
// - Relative current only on solenoid outputs
// - States indexed zero to 63
// - Target-reached outputs report end positions
module msq_sequencer (
  // Clock, reset, enable
  input  wire logic                                   clock_in,
  input  wire logic                                   resetn_in,
  input  wire logic                                   ce_in,
  // Trigger pins from the master
  input  wire logic [msq_pkg::IDX_W-1:0]              trig_index_in,
  input  wire logic                                   trig_strobe_in,
  // Table load port
  input  wire logic                                   load_en_in,
  input  wire logic [msq_pkg::IDX_W-1:0]              load_state_in,
  input  wire logic [msq_pkg::AXIS_W-1:0]             load_axis_in,
  input  wire msq_pkg::msq_entry_type                 load_entry_in,
  // Actuator configuration and feedback
  input  wire logic [msq_pkg::AXES-1:0]               solenoid_in,
  input  wire logic [msq_pkg::AXES-1:0]               arrived_in,
  // Actuator commands
  output var  msq_pkg::msq_axis_type [msq_pkg::AXES-1:0] axis_out,
  output logic [msq_pkg::AXES-1:0]                    start_out,
  // Status to the master
  output logic [msq_pkg::AXES-1:0]                    in_pos_out,
  output logic                                        busy_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser
  localparam int unsigned TW = msq_pkg::IDX_W + 1;

  logic [TW-1:0] trig_meta;
  logic [TW-1:0] trig_sync;
  logic          strobe_prev;
  logic          strobe_rise;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trig_meta   <= '0;
      trig_sync   <= '0;
      strobe_prev <= 1'b0;
    end else if (ce_in) begin
      trig_meta   <= {trig_strobe_in, trig_index_in};
      trig_sync   <= trig_meta;
      strobe_prev <= trig_sync[TW-1];
    end
  end

  assign strobe_rise = trig_sync[TW-1] & ~strobe_prev;

  ////////////////////////////////////////////////////////////////////////////
  // State table memory
  msq_pkg::msq_entry_type [msq_pkg::AXES-1:0] state_mem [msq_pkg::STATES];
  msq_pkg::msq_entry_type [msq_pkg::AXES-1:0] row;
  msq_pkg::msq_entry_type [msq_pkg::AXES-1:0] next_row;
  logic [msq_pkg::IDX_W-1:0]                  sel_index;

  always_comb begin
    next_row = state_mem[sel_index];
  end

  always_ff @(posedge clock_in) begin
    if (ce_in) begin
      if (load_en_in) begin
        state_mem[load_state_in][load_axis_in] <= load_entry_in;
      end
      row <= next_row;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer control
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FETCH,
    SEQ_APPLY
  } msq_seq_type;

  msq_seq_type               seq;
  msq_seq_type               next_seq;
  logic [msq_pkg::IDX_W-1:0] next_sel_index;

  always_comb begin
    next_seq       = seq;
    next_sel_index = sel_index;
    case (seq)
      SEQ_IDLE: begin
        if (strobe_rise) begin
          next_sel_index = trig_sync[msq_pkg::IDX_W-1:0];
          next_seq       = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        next_seq = SEQ_APPLY;
      end
      SEQ_APPLY: begin
        next_seq = SEQ_IDLE;
      end
      default: begin
        next_seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seq       <= SEQ_IDLE;
      sel_index <= '0;
    end else if (ce_in) begin
      seq       <= next_seq;
      sel_index <= next_sel_index;
    end
  end

  assign busy_out = (seq != SEQ_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Per-actuator command state
  msq_pkg::msq_axis_type [msq_pkg::AXES-1:0] axis;
  msq_pkg::msq_axis_type [msq_pkg::AXES-1:0] next_axis;
  logic [msq_pkg::AXES-1:0]                  moving;
  logic [msq_pkg::AXES-1:0]                  next_moving;
  logic [msq_pkg::AXES-1:0]                  in_pos;
  logic [msq_pkg::AXES-1:0]                  next_in_pos;
  logic [msq_pkg::AXES-1:0]                  start;
  logic [msq_pkg::AXES-1:0]                  next_start;

  always_comb begin
    next_axis   = axis;
    next_moving = moving;
    next_in_pos = in_pos;
    next_start  = '0;
    for (int a = 0; a < msq_pkg::AXES; a++) begin
      if (moving[a] && arrived_in[a]) begin
        next_moving[a] = 1'b0;
        next_in_pos[a] = 1'b1;
      end
      if (seq == SEQ_APPLY) begin
        case (row[a].op)
          msq_pkg::OP_NOP: begin
            next_axis[a] = axis[a];
          end
          msq_pkg::OP_ABS_POS: begin
            next_axis[a].target = row[a].value;
            next_axis[a].speed  = row[a].speed;
            next_axis[a].accel  = row[a].accel;
            next_moving[a]      = 1'b1;
            next_in_pos[a]      = 1'b0;
            next_start[a]       = 1'b1;
          end
          msq_pkg::OP_REL_POS: begin
            next_axis[a].target = axis[a].target + row[a].value;
            next_axis[a].speed  = row[a].speed;
            next_axis[a].accel  = row[a].accel;
            next_moving[a]      = 1'b1;
            next_in_pos[a]      = 1'b0;
            next_start[a]       = 1'b1;
          end
          msq_pkg::OP_ABS_CUR: begin
            if (solenoid_in[a]) begin
              next_axis[a].current = row[a].value[msq_pkg::CUR_W-1:0];
            end
          end
          msq_pkg::OP_REL_CUR: begin
            if (solenoid_in[a]) begin
              next_axis[a].current = axis[a].current
                + row[a].value[msq_pkg::CUR_W-1:0];
            end
          end
          default: begin
            next_axis[a] = axis[a];
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int a = 0; a < msq_pkg::AXES; a++) begin
        axis[a].target  <= msq_pkg::TARGET_RST;
        axis[a].speed   <= msq_pkg::LIMIT_RST;
        axis[a].accel   <= msq_pkg::LIMIT_RST;
        axis[a].current <= msq_pkg::CUR_RST;
      end
      moving <= '0;
      in_pos <= {msq_pkg::AXES{msq_pkg::INPOS_RST}};
      start  <= '0;
    end else if (ce_in) begin
      axis   <= next_axis;
      moving <= next_moving;
      in_pos <= next_in_pos;
      start  <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign axis_out   = axis;
  assign start_out  = start;
  assign in_pos_out = in_pos;

endmodule : msq_sequencer

`default_nettype wire

// file: msq_sequencer_chk.sv
// Port checker for the motion state table sequencer
`timescale 1ns/10ps
`default_nettype none
module msq_sequencer_chk (
  // Clock and reset
  input wire logic                        clock_in,
  input wire logic                        resetn_in,
  input wire logic                        ce_in,
  // Watched pins
  input wire logic                        trig_strobe_in,
  input wire logic [3:0]                  arrived_in,
  input wire msq_pkg::msq_axis_type [3:0] axis_out,
  input wire logic [3:0]                  start_out,
  input wire logic [3:0]                  in_pos_out,
  input wire logic                        busy_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  chk_take_strobe: assert property (
    $rose(trig_strobe_in) && !busy_out |-> ##[2:4] busy_out)
    else $error("strobe not taken");
  chk_busy_len: assert property (
    $rose(busy_out) |-> busy_out[*2] ##1 !busy_out) else $error("busy len");
  chk_start_apply: assert property (
    start_out != 4'h0 |-> $fell(busy_out)) else $error("stray start");
  chk_start_pulse: assert property (
    start_out != 4'h0 && ce_in |=> start_out == 4'h0)
    else $error("start long");
  chk_start_clears: assert property (
    (start_out & in_pos_out) == 4'h0) else $error("start with in_pos");
  chk_arrive_sets: assert property (
    ce_in && ((arrived_in & ~in_pos_out) != 4'h0) && !busy_out
    |=> ($past(arrived_in & ~in_pos_out) & ~in_pos_out) == 4'h0)
    else $error("arrival lost");
  chk_pos_rise: assert property (
    (in_pos_out & ~$past(in_pos_out) & ~$past(arrived_in)) == 4'h0)
    else $error("in_pos rose alone");
  chk_pos_drop: assert property (
    (~in_pos_out & $past(in_pos_out) & ~start_out) == 4'h0)
    else $error("in_pos fell alone");
  chk_axis_hold: assert property (
    !busy_out |=> $stable(axis_out)) else $error("axis moved idle");
  chk_freeze_hold: assert property (
    !ce_in |=> $stable(in_pos_out) && $stable(axis_out) && $stable(start_out))
    else $error("state moved while frozen");
  cover property ($fell(busy_out));
  cover property (start_out != 4'h0);
  cover property ((arrived_in & ~in_pos_out) != 4'h0);
  cover property (!ce_in && (arrived_in & ~in_pos_out) != 4'h0);
endmodule : msq_sequencer_chk
bind msq_sequencer msq_sequencer_chk msq_sequencer_chk_inst (.clock_in,
  .resetn_in, .ce_in, .trig_strobe_in, .arrived_in, .axis_out, .start_out,
  .in_pos_out, .busy_out);
`default_nettype wire

// file: msq_master.sv
// Master controller model driving the trigger pins
`timescale 1ns/10ps
`default_nettype none
module msq_master (
  // Clock
  input  wire logic       clock_in,
  // Trigger pins
  output var  logic [5:0] index_out,
  output var  logic       strobe_out
);
  initial begin
    index_out = 6'h2a;
    strobe_out = 1'b0;
  end
  // Index first, strobe rises three clocks later
  task automatic sel(input logic [5:0] idx);
    @(posedge clock_in) #1 index_out = idx;
    repeat (3) @(posedge clock_in);
    #1 strobe_out = 1'b1;
  endtask : sel
  // Strobe low, index no longer valid
  task automatic rel();
    @(posedge clock_in) #1 strobe_out = 1'b0;
    index_out = ~index_out;
    repeat (3) @(posedge clock_in);
  endtask : rel
endmodule : msq_master
`default_nettype wire

// file: tb_msq_sequencer.sv
// Self-checking bench for the motion state table sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_msq_sequencer;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_in = 1'b1;
  logic load_en_in = 1'b0;
  logic [5:0] load_state_in = 6'h00;
  logic [1:0] load_axis_in = 2'h0;
  msq_pkg::msq_entry_type load_entry_in = '0;
  logic [3:0] solenoid_in = 4'h0;
  logic [3:0] arrived_in = 4'h0;
  logic [5:0] trig_index;
  logic trig_strobe;
  msq_pkg::msq_axis_type [3:0] axis_out;
  msq_pkg::msq_axis_type [3:0] exp_axis = '0;
  logic [3:0] start_out, in_pos_out, exp_start = 4'h0, exp_pos = 4'hf;
  logic busy_out;
  int num_errors = 0;
  int check_count = 0;
  always #5 clock_in = ~clock_in;
  msq_sequencer msq_sequencer_inst (.clock_in, .resetn_in, .ce_in,
    .trig_index_in(trig_index), .trig_strobe_in(trig_strobe), .load_en_in,
    .load_state_in, .load_axis_in, .load_entry_in, .solenoid_in,
    .arrived_in, .axis_out, .start_out, .in_pos_out, .busy_out);
  msq_master msq_master_inst (.clock_in, .index_out(trig_index),
    .strobe_out(trig_strobe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic wait_busy(input logic lvl);
    for (int n = 0; busy_out !== lvl; n++) begin
      if (n > 20) begin
        num_errors++;
        stop_test();
      end
      @(posedge clock_in) #2;
    end
  endtask : wait_busy
  task automatic check_all();
    for (int k = 0; k < 4; k++) chk(axis_out[k], exp_axis[k]);
    chk(start_out, exp_start);
    chk(in_pos_out, exp_pos);
  endtask : check_all
  function automatic msq_pkg::msq_axis_type nxt(msq_pkg::msq_entry_type e,
      msq_pkg::msq_axis_type a, logic s);
    nxt = a;
    case (e.op)
      msq_pkg::OP_ABS_POS: nxt = '{e.value, e.speed, e.accel, a.current};
      msq_pkg::OP_REL_POS: nxt = '{a.target + e.value, e.speed, e.accel,
                                   a.current};
      msq_pkg::OP_ABS_CUR: if (s) nxt.current = e.value[15:0];
      msq_pkg::OP_REL_CUR: if (s) nxt.current = a.current + e.value[15:0];
      default: ;
    endcase
  endfunction : nxt
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    msq_pkg::msq_entry_type e;
    logic [5:0] st;
    void'($urandom(32'h14f0));
    repeat (8) @(posedge clock_in);
    #1 resetn_in = 1'b1;
    check_all();
    for (int i = 0; i < 40; i++) begin
      st = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
      @(posedge clock_in) #1 solenoid_in = 4'($urandom);
      for (int k = 0; k < 4; k++) begin
        e.op = msq_pkg::msq_op_type'(3'($urandom_range(7)));
        e.value = $urandom;
        e.speed = 16'($urandom);
        e.accel = 16'($urandom);
        load_en_in = 1'b1;
        load_state_in = st;
        load_axis_in = 2'(k);
        load_entry_in = e;
        exp_axis[k] = nxt(e, exp_axis[k], solenoid_in[k]);
        exp_start[k] = e.op inside {msq_pkg::OP_ABS_POS, msq_pkg::OP_REL_POS};
        @(posedge clock_in) #1;
      end
      load_en_in = 1'b0;
      exp_pos = exp_pos & ~exp_start;
      msq_master_inst.sel(st);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check_all();
      @(posedge clock_in) #1 arrived_in = 4'($urandom);
      if (i % 8 == 3) begin
        ce_in = 1'b0;
        repeat (3) @(posedge clock_in) #1;
        chk(in_pos_out, exp_pos);
        ce_in = 1'b1;
        @(posedge clock_in) #1;
      end
      exp_pos = exp_pos | arrived_in;
      @(posedge clock_in) #1 arrived_in = 4'h0;
      chk(in_pos_out, exp_pos);
      msq_master_inst.rel();
    end
    stop_test();
  end
endmodule : tb_msq_sequencer
`default_nettype wire
